// ===== rtl/iss_pkg.sv
// shared constants, types and carriers of the serial slave block
package iss_pkg;
    // ==============================================================
    // address matching and byte framing
    localparam logic [4:0] TEN_BIT_PREFIX = 5'h1e;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam int ADDR_TEN_HI_POS = 3;
    localparam int ADDR_TEN_HI_TOP = 2;
    localparam int ADDR_TEN_HI_LOW = 1;
    localparam int ADDR_SEVEN_LOW = 1;

    // ==============================================================
    // reset values
    localparam logic [7:0] OWN_ADDR_RESET = 8'h00;
    localparam logic [7:0] BUFFER_RESET = 8'h00;
    localparam logic CLOCK_RELEASE_RESET = 1'h1;

    // ==============================================================
    // software events, index into the request vector
    localparam int EV_BUF_WRITE = 0;
    localparam int EV_BUF_READ = 1;
    localparam int EV_CKP_SET = 2;
    localparam int EV_ADDR_WRITE = 3;
    localparam int EV_IRQ_CLEAR = 4;
    localparam int EV_BCL_CLEAR = 5;
    localparam int EV_COUNT = 6;

    // ==============================================================
    // states and phases
    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,
        ST_RXBYTE = 5'h02,
        ST_ACKOUT = 5'h04,
        ST_TXBYTE = 5'h08,
        ST_TXACK = 5'h10
    } iss_state_t;

    typedef enum logic [2:0] {
        PH_ADDR_HI = 3'h1,
        PH_ADDR_LO = 3'h2,
        PH_DATA = 3'h4
    } iss_phase_t;

    // ==============================================================
    // carriers
    typedef struct packed {
        logic tenBitMode;
        logic startIrqEn;
        logic addressHoldEn;
        logic dataHoldEn;
        logic stretchEnable;
        logic slaveCollisionDetectEn;
        logic ackValueBit;
    } iss_cfg_t;

    typedef struct packed {
        logic bclClear;
        logic irqClear;
        logic addrWrite;
        logic ckpSet;
        logic bufRead;
        logic bufWrite;
    } iss_req_t;

    typedef struct packed {
        logic [7:0] rxTxBuffer;
        logic bufferFullFlag;
        logic serialIrqFlag;
        logic readWriteFlag;
        logic dataNotAddressFlag;
        logic ackTimeFlag;
        logic masterAckStatus;
        logic startSeenFlag;
        logic stopSeenFlag;
        logic addressUpdateFlag;
        logic busCollisionFlag;
        logic clockReleaseBit;
        logic addressed;
    } iss_stat_t;
endpackage : iss_pkg

// ===== rtl/iss_slave.sv
// serial bus slave: transmit path, collision, holds, 10-bit addressing
// Notes on behaviour
// - read address match: flag, buffer, acknowledge
// - after read acknowledge clear release, hold clock
// - buffer write loads shifter; release sends byte
// - transmit bits change on falling clock
// - master acknowledge captured on ninth rise
// - master no-acknowledge ends transfer, goes idle
// - master acknowledge stretches clock again
// - irq flag on ninth fall, software clears
// - enabled collision sets flag, goes idle
// - start sets flag, irq when enabled
// - address hold: stretch, irq before acknowledge
// - hold shows ack time, direction, data flags
// - buffer write sets full, read clears
// - restart or stop ends addressed state
// - ten-bit high write: update flag, hold
// - own address write releases the clock
// - low mismatch: irq, update flag, no full
// - stretch enable holds after each byte except the ten-bit high and low address bytes
// - ten-bit holds behave as seven-bit
// - ten-bit high compare against fixed prefix
// - hold only once clock seen low
`timescale 1ns/100ps
`default_nettype none
module iss_slave (
    input wire logic clock,
    input wire logic resetn,
    input wire logic linkClock,
    input wire logic sclIn,
    input wire logic sdaIn,
    output logic sclOut,
    output logic sclOe,
    output logic sdaOut,
    output logic sdaOe,
    input wire iss_pkg::iss_cfg_t cfg,
    input wire iss_pkg::iss_req_t req,
    input wire logic [7:0] bufWriteData,
    input wire logic [7:0] addrWriteData,
    output iss_pkg::iss_stat_t status
);
    // ==============================================================
    // system clock side: event toggles, held data, status capture
    logic [iss_pkg::EV_COUNT-1:0] evTog_r, evTog_nxt;
    logic [7:0] wrData_r, wrData_nxt, adrData_r, adrData_nxt;
    iss_pkg::iss_stat_t statA_r, statB_r, linkStat;

    always_comb begin
        evTog_nxt = evTog_r ^ req;
        wrData_nxt = req.bufWrite ? bufWriteData : wrData_r;
        adrData_nxt = req.addrWrite ? addrWriteData : adrData_r;
    end

    // data words stay put until the next strobe; a toggle carries the
    // event, so two strobes must be a few link cycles apart
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            evTog_r <= '0;
            wrData_r <= iss_pkg::BUFFER_RESET;
            adrData_r <= iss_pkg::OWN_ADDR_RESET;
            statA_r <= '0;
            statB_r <= '0;
        end else begin
            evTog_r <= evTog_nxt;
            wrData_r <= wrData_nxt;
            adrData_r <= adrData_nxt;
            statA_r <= linkStat;
            statB_r <= statA_r;
        end
    end
    assign status = statB_r;

    // ==============================================================
    // link side: reset release, pin and event synchronisers
    logic [1:0] rstS_r;
    logic linkRstn;
    always_ff @(posedge linkClock or negedge resetn) begin
        if (!resetn) begin
            rstS_r <= 2'h0;
        end else begin
            rstS_r <= {rstS_r[0], 1'h1};
        end
    end
    assign linkRstn = rstS_r[1];

    logic [1:0] sclS_r, sdaS_r;
    logic sclD_r, sdaD_r;
    logic [iss_pkg::EV_COUNT-1:0] evA_r, evB_r, evC_r, ev;
    iss_pkg::iss_cfg_t cfgA_r, cfgB_r;
    always_ff @(posedge linkClock or negedge linkRstn) begin
        if (!linkRstn) begin
            sclS_r <= 2'h3;
            sdaS_r <= 2'h3;
            sclD_r <= 1'h1;
            sdaD_r <= 1'h1;
            evA_r <= '0;
            evB_r <= '0;
            evC_r <= '0;
            cfgA_r <= '0;
            cfgB_r <= '0;
        end else begin
            sclS_r <= {sclS_r[0], sclIn};
            sdaS_r <= {sdaS_r[0], sdaIn};
            sclD_r <= sclS_r[1];
            sdaD_r <= sdaS_r[1];
            evA_r <= evTog_r;
            evB_r <= evA_r;
            evC_r <= evB_r;
            cfgA_r <= cfg;
            cfgB_r <= cfgA_r;
        end
    end

    logic scl, sda, sclRise, sclFall, startCond, stopCond;
    assign scl = sclS_r[1];
    assign sda = sdaS_r[1];
    assign sclRise = scl && !sclD_r;
    assign sclFall = !scl && sclD_r;
    assign startCond = scl && sclD_r && sdaD_r && !sda;
    assign stopCond = scl && sclD_r && !sdaD_r && sda;
    assign ev = evB_r ^ evC_r;

    // ==============================================================
    // link side: protocol engine
    iss_pkg::iss_state_t st_r, st_nxt;
    iss_pkg::iss_phase_t ph_r, ph_nxt;
    logic [3:0] bit_r, bit_nxt;
    logic [7:0] shf_r, shf_nxt, buf_r, buf_nxt, own_r, own_nxt;
    logic full_r, full_nxt, irq_r, irq_nxt, rw_r, rw_nxt;
    logic dna_r, dna_nxt, ackTime_r, ackTime_nxt, mack_r, mack_nxt;
    logic start_r, start_nxt, stop_r, stop_nxt, ua_r, ua_nxt;
    logic uaHold_r, uaHold_nxt, bcl_r, bcl_nxt, ckp_r, ckp_nxt;
    logic adr_r, adr_nxt, tenOk_r, tenOk_nxt, ackLow_r, ackLow_nxt;
    logic useCfg_r, useCfg_nxt, sclOe_r, sclOe_nxt, sdaOe_r, sdaOe_nxt;
    logic lowOut_r, match, holdAck, collide;

    function automatic logic addrMatch(input iss_pkg::iss_phase_t ph,
                                       input logic [7:0] rx,
                                       input logic [7:0] own,
                                       input logic ten,
                                       input logic tenOk);
        logic hiTen;
        hiTen = rx[7:iss_pkg::ADDR_TEN_HI_POS] == iss_pkg::TEN_BIT_PREFIX
             && rx[iss_pkg::ADDR_TEN_HI_TOP:iss_pkg::ADDR_TEN_HI_LOW]
             == own[iss_pkg::ADDR_TEN_HI_TOP:iss_pkg::ADDR_TEN_HI_LOW]
             && (!rx[0] || tenOk);
        if (ph == iss_pkg::PH_ADDR_HI) begin
            addrMatch = ten ? hiTen
                : rx[7:iss_pkg::ADDR_SEVEN_LOW]
                  == own[7:iss_pkg::ADDR_SEVEN_LOW];
        end else if (ph == iss_pkg::PH_ADDR_LO) begin
            addrMatch = rx == own;
        end else begin
            addrMatch = 1'h1;
        end
    endfunction : addrMatch

    always_comb begin
        st_nxt = st_r;
        ph_nxt = ph_r;
        bit_nxt = bit_r;
        shf_nxt = shf_r;
        buf_nxt = buf_r;
        own_nxt = own_r;
        full_nxt = full_r;
        irq_nxt = irq_r;
        rw_nxt = rw_r;
        dna_nxt = dna_r;
        ackTime_nxt = ackTime_r;
        mack_nxt = mack_r;
        start_nxt = start_r;
        stop_nxt = stop_r;
        ua_nxt = ua_r;
        uaHold_nxt = uaHold_r;
        bcl_nxt = bcl_r;
        ckp_nxt = ckp_r;
        adr_nxt = adr_r;
        tenOk_nxt = tenOk_r;
        ackLow_nxt = ackLow_r;
        useCfg_nxt = useCfg_r;
        match = addrMatch(ph_r, shf_r, own_r, cfgB_r.tenBitMode, tenOk_r);
        holdAck = match && (ph_r == iss_pkg::PH_DATA
            ? cfgB_r.dataHoldEn : cfgB_r.addressHoldEn);
        collide = st_r == iss_pkg::ST_TXBYTE && scl && sclD_r
            && shf_r[7] && !sda && bit_r < iss_pkg::BITS_PER_BYTE;
        // software side first, so hardware events below win
        if (ev[iss_pkg::EV_BUF_READ]) full_nxt = 1'h0;
        if (ev[iss_pkg::EV_BUF_WRITE]) begin
            buf_nxt = wrData_r;
            shf_nxt = wrData_r;
            full_nxt = 1'h1;
        end
        if (ev[iss_pkg::EV_CKP_SET]) ckp_nxt = 1'h1;
        if (ev[iss_pkg::EV_ADDR_WRITE]) begin
            own_nxt = adrData_r;
            ua_nxt = 1'h0;
            uaHold_nxt = 1'h0;
        end
        if (ev[iss_pkg::EV_IRQ_CLEAR]) irq_nxt = 1'h0;
        if (ev[iss_pkg::EV_BCL_CLEAR]) bcl_nxt = 1'h0;
        unique case (st_r)
            iss_pkg::ST_IDLE: begin
            end
            iss_pkg::ST_RXBYTE: begin
                if (sclRise && bit_r < iss_pkg::BITS_PER_BYTE) begin
                    shf_nxt = {shf_r[6:0], sda};
                    bit_nxt = bit_r + 4'h1;
                end else if (sclFall && bit_r == iss_pkg::BITS_PER_BYTE) begin
                    bit_nxt = 4'h0;
                    if (!match && ph_r == iss_pkg::PH_ADDR_HI) begin
                        st_nxt = iss_pkg::ST_IDLE;
                    end else begin
                        st_nxt = iss_pkg::ST_ACKOUT;
                        if (ph_r == iss_pkg::PH_ADDR_HI) rw_nxt = shf_r[0];
                        dna_nxt = ph_r == iss_pkg::PH_DATA;
                        if (match) begin
                            buf_nxt = shf_r;
                            full_nxt = 1'h1;
                        end
                        // a full buffer withholds the acknowledge but still takes the byte
                        ackLow_nxt = match && !full_r;
                        useCfg_nxt = holdAck;
                        if (holdAck) begin
                            ckp_nxt = 1'h0;
                            irq_nxt = 1'h1;
                            ackTime_nxt = 1'h1;
                        end
                        if (match && ph_r == iss_pkg::PH_ADDR_LO) begin
                            tenOk_nxt = 1'h1;
                        end
                    end
                end
            end
            iss_pkg::ST_ACKOUT: begin
                if (useCfg_r) ackLow_nxt = !cfgB_r.ackValueBit;
                if (sclFall) begin
                    ackTime_nxt = 1'h0;
                    if (ph_r == iss_pkg::PH_ADDR_LO) begin
                        ua_nxt = 1'h1;
                        uaHold_nxt = 1'h1;
                        irq_nxt = 1'h1;
                    end
                    if (!ackLow_r) begin
                        st_nxt = iss_pkg::ST_IDLE;
                    end else begin
                        irq_nxt = 1'h1;
                        adr_nxt = ph_r != iss_pkg::PH_ADDR_HI
                            || !cfgB_r.tenBitMode || rw_r;
                        if (ph_r == iss_pkg::PH_ADDR_HI
                            && cfgB_r.tenBitMode && !rw_r) begin
                            ua_nxt = 1'h1;
                            uaHold_nxt = 1'h1;
                            ph_nxt = iss_pkg::PH_ADDR_LO;
                            st_nxt = iss_pkg::ST_RXBYTE;
                        end else if (rw_r) begin
                            ckp_nxt = 1'h0;
                            st_nxt = iss_pkg::ST_TXBYTE;
                        end else begin
                            ph_nxt = iss_pkg::PH_DATA;
                            st_nxt = iss_pkg::ST_RXBYTE;
                            if (cfgB_r.stretchEnable
                                && ph_r != iss_pkg::PH_ADDR_LO) begin
                                ckp_nxt = 1'h0;
                            end
                        end
                    end
                end
            end
            iss_pkg::ST_TXBYTE: begin
                if (collide && cfgB_r.slaveCollisionDetectEn) begin
                    bcl_nxt = 1'h1;
                    st_nxt = iss_pkg::ST_IDLE;
                    adr_nxt = 1'h0;
                end else if (sclRise) begin
                    bit_nxt = bit_r + 4'h1;
                end else if (sclFall && bit_r == iss_pkg::BITS_PER_BYTE) begin
                    st_nxt = iss_pkg::ST_TXACK;
                end else if (sclFall && bit_r != 4'h0) begin
                    shf_nxt = {shf_r[6:0], 1'h1};
                end
            end
            iss_pkg::ST_TXACK: begin
                if (sclRise) mack_nxt = sda;
                if (sclFall) begin
                    irq_nxt = 1'h1;
                    bit_nxt = 4'h0;
                    if (mack_r) begin
                        st_nxt = iss_pkg::ST_IDLE;
                        adr_nxt = 1'h0;
                    end else begin
                        ckp_nxt = 1'h0;
                        st_nxt = iss_pkg::ST_TXBYTE;
                    end
                end
            end
        endcase
        if (startCond) begin
            start_nxt = 1'h1;
            stop_nxt = 1'h0;
            if (cfgB_r.startIrqEn) irq_nxt = 1'h1;
            adr_nxt = 1'h0;
            st_nxt = iss_pkg::ST_RXBYTE;
            ph_nxt = iss_pkg::PH_ADDR_HI;
            bit_nxt = 4'h0;
        end else if (stopCond) begin
            stop_nxt = 1'h1;
            start_nxt = 1'h0;
            adr_nxt = 1'h0;
            tenOk_nxt = 1'h0;
            st_nxt = iss_pkg::ST_IDLE;
        end
        // grab the line only once it is already low
        sclOe_nxt = (!ckp_nxt || uaHold_nxt) && (sclOe_r || !scl);
        sdaOe_nxt = (st_nxt == iss_pkg::ST_ACKOUT && ackLow_nxt)
            || (st_nxt == iss_pkg::ST_TXBYTE && !shf_nxt[7]);
    end

    always_ff @(posedge linkClock or negedge linkRstn) begin
        if (!linkRstn) begin
            st_r <= iss_pkg::ST_IDLE;
            ph_r <= iss_pkg::PH_ADDR_HI;
            bit_r <= 4'h0;
            shf_r <= iss_pkg::BUFFER_RESET;
            buf_r <= iss_pkg::BUFFER_RESET;
            own_r <= iss_pkg::OWN_ADDR_RESET;
            {full_r, irq_r, rw_r, dna_r, ackTime_r, mack_r} <= 6'h0;
            {start_r, stop_r, ua_r, uaHold_r, bcl_r} <= 5'h0;
            ckp_r <= iss_pkg::CLOCK_RELEASE_RESET;
            {adr_r, tenOk_r, ackLow_r, useCfg_r} <= 4'h0;
            {sclOe_r, sdaOe_r, lowOut_r} <= 3'h0;
        end else begin
            st_r <= st_nxt;
            ph_r <= ph_nxt;
            bit_r <= bit_nxt;
            shf_r <= shf_nxt;
            buf_r <= buf_nxt;
            own_r <= own_nxt;
            {full_r, irq_r, rw_r, dna_r, ackTime_r, mack_r} <=
                {full_nxt, irq_nxt, rw_nxt, dna_nxt, ackTime_nxt, mack_nxt};
            {start_r, stop_r, ua_r, uaHold_r, bcl_r} <=
                {start_nxt, stop_nxt, ua_nxt, uaHold_nxt, bcl_nxt};
            ckp_r <= ckp_nxt;
            {adr_r, tenOk_r, ackLow_r, useCfg_r} <=
                {adr_nxt, tenOk_nxt, ackLow_nxt, useCfg_nxt};
            {sclOe_r, sdaOe_r, lowOut_r} <= {sclOe_nxt, sdaOe_nxt, 1'h0};
        end
    end

    assign sclOe = sclOe_r;
    assign sdaOe = sdaOe_r;
    assign sclOut = lowOut_r;
    assign sdaOut = lowOut_r;
    // multi-bit status is resampled every cycle; it settles within two
    assign linkStat = '{rxTxBuffer: buf_r, bufferFullFlag: full_r,
        serialIrqFlag: irq_r, readWriteFlag: rw_r,
        dataNotAddressFlag: dna_r, ackTimeFlag: ackTime_r,
        masterAckStatus: mack_r, startSeenFlag: start_r,
        stopSeenFlag: stop_r, addressUpdateFlag: ua_r,
        busCollisionFlag: bcl_r, clockReleaseBit: ckp_r,
        addressed: adr_r};

    // ==============================================================
    // checks
    default clocking cb @(posedge linkClock); endclocking
    default disable iff (!linkRstn);

    sequence readAckEnd;
        st_r == iss_pkg::ST_ACKOUT && sclFall && ackLow_r && rw_r
            && !startCond && !stopCond;
    endsequence
    sequence txByteEnd;
        st_r == iss_pkg::ST_TXACK && sclFall && !startCond && !stopCond;
    endsequence
    sequence sclHighTx;
        st_r == iss_pkg::ST_TXBYTE ##0 scl && sclD_r && !collide;
    endsequence

    a_read_ack_hold: assert property (
        readAckEnd |=> !ckp_r && st_r == iss_pkg::ST_TXBYTE)
        else $error("read acknowledge did not stretch the clock");
    a_hold_when_low: assert property (
        $rose(sclOe_r) |-> !$past(scl))
        else $error("clock grabbed while high");
    a_mack_capture: assert property (
        st_r == iss_pkg::ST_TXACK && sclRise |=> mack_r == $past(sda))
        else $error("master acknowledge not captured");
    a_nack_idle: assert property (
        txByteEnd ##0 mack_r |=> st_r == iss_pkg::ST_IDLE && irq_r
            && !adr_r)
        else $error("no-acknowledge did not end transfer");
    a_ack_restretch: assert property (
        txByteEnd ##0 !mack_r |=> irq_r && !ckp_r ##1 sclOe_r)
        else $error("acknowledged byte not stretched");
    a_buf_full: assert property (
        ev[iss_pkg::EV_BUF_WRITE] |=> full_r && buf_r == $past(wrData_r))
        else $error("buffer write did not set full");
    a_tx_stable: assert property (
        sclHighTx |=> $stable(sdaOe_r) || st_r != iss_pkg::ST_TXBYTE)
        else $error("transmit data moved while clock high");
    a_start_flag: assert property (
        startCond && cfgB_r.startIrqEn |=> start_r && irq_r
            && st_r == iss_pkg::ST_RXBYTE)
        else $error("start not flagged");
    a_addr_release: assert property (
        ev[iss_pkg::EV_ADDR_WRITE] && !stopCond && !startCond
            && st_r == iss_pkg::ST_IDLE |=> !uaHold_r && !ua_r)
        else $error("address write did not release");
    a_collision_idle: assert property (
        collide && cfgB_r.slaveCollisionDetectEn && !startCond
            && !stopCond |=> bcl_r && st_r == iss_pkg::ST_IDLE)
        else $error("collision not handled");
endmodule : iss_slave
`default_nettype wire

// ===== testbench/i2c_slave_tx_and_10bit_rx_test.sv
// self-checking bench of the serial slave against a master model
`timescale 1ns/100ps
`default_nettype none
module i2c_slave_tx_and_10bit_rx_test;
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] data;
        logic match;
    } iss_row_t;
    logic clock, resetn, linkClock, sclBus, sdaBus, sclOe, sdaOe;
    logic mSclLow, mSdaLow, hung, ack;
    logic [7:0] bufWriteData, addrWriteData, got;
    iss_pkg::iss_cfg_t cfg;
    iss_pkg::iss_req_t req;
    iss_pkg::iss_stat_t status;
    int num_errors, tests_run;
    iss_row_t rows [4] = '{'{8'ha1, 8'h5a, 1'b1}, '{8'hb1, 8'h11, 1'b0},
                           '{8'ha1, 8'h80, 1'b1}, '{8'ha1, 8'h01, 1'b1}};
    // pull-ups on both lines; any party pulling low wins
    assign sclBus = ~(mSclLow | sclOe);
    assign sdaBus = ~(mSdaLow | sdaOe);
    iss_slave uut (.clock(clock), .resetn(resetn), .linkClock(linkClock),
        .sclIn(sclBus), .sdaIn(sdaBus), .sclOut(), .sclOe(sclOe),
        .sdaOut(), .sdaOe(sdaOe), .cfg(cfg), .req(req),
        .bufWriteData(bufWriteData), .addrWriteData(addrWriteData),
        .status(status));
    iss_master_model mdl (.clock(clock), .sclBus(sclBus), .sdaBus(sdaBus),
        .sclLow(mSclLow), .sdaLow(mSdaLow), .hung(hung));
    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end
    initial begin
        linkClock = 1'b0;
        #3;
        forever #7.5 linkClock = ~linkClock;
    end
    // ==========================================================
    // helpers
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : report_and_stop
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    // spacing keeps strobes apart and lets status settle
    task automatic sw(input int idx, input logic [7:0] d);
        @(posedge clock);
        req <= iss_pkg::iss_req_t'(6'h01 << idx);
        bufWriteData <= d;
        addrWriteData <= d;
        @(posedge clock);
        req <= '0;
        repeat (14) @(posedge clock);
    endtask : sw
    always @(posedge clock) begin
        if (hung) begin
            num_errors++;
            report_and_stop();
        end
    end
    // ==========================================================
    // sequence
    initial begin
        num_errors = 0;
        tests_run = 0;
        resetn = 1'b0;
        cfg = '0;
        cfg.startIrqEn = 1'b1;
        cfg.slaveCollisionDetectEn = 1'b1;
        req = '0;
        bufWriteData = 8'h00;
        addrWriteData = 8'h00;
        repeat (3) @(posedge clock);
        resetn <= 1'b1;
        repeat (4) @(posedge clock);
        chk(status.clockReleaseBit, 8'h01);
        chk(status.serialIrqFlag, 8'h00);
        sw(iss_pkg::EV_ADDR_WRITE, 8'ha0);
        foreach (rows[i]) begin
            mdl.start();
            chk(status.startSeenFlag, 8'h01);
            chk(status.serialIrqFlag, 8'h01);
            sw(iss_pkg::EV_IRQ_CLEAR, 8'h00);
            mdl.writeByte(rows[i].addr, ack);
            chk(ack, rows[i].match);
            if (rows[i].match) begin
                repeat (14) @(posedge clock);
                chk(status.readWriteFlag, 8'h01);
                chk(status.rxTxBuffer, rows[i].addr);
                chk(status.serialIrqFlag, 8'h01);
                chk(status.clockReleaseBit, 8'h00);
                chk(sclOe, 8'h01);
                sw(iss_pkg::EV_IRQ_CLEAR, 8'h00);
                sw(iss_pkg::EV_BUF_READ, 8'h00);
                chk(status.bufferFullFlag, 8'h00);
                sw(iss_pkg::EV_BUF_WRITE, rows[i].data);
                chk(status.bufferFullFlag, 8'h01);
                sw(iss_pkg::EV_CKP_SET, 8'h00);
                mdl.readByte(1'b0, 1'b1, got);
                chk(got, rows[i].data);
                // the ninth fall is seen by the slave after the model returns
                repeat (14) @(posedge clock);
                chk(status.masterAckStatus, 8'h00);
                chk(status.serialIrqFlag, 8'h01);
                chk(status.clockReleaseBit, 8'h00);
                chk(sclOe, 8'h01);
                sw(iss_pkg::EV_IRQ_CLEAR, 8'h00);
                sw(iss_pkg::EV_BUF_WRITE, ~rows[i].data);
                sw(iss_pkg::EV_CKP_SET, 8'h00);
                mdl.readByte(1'b0, 1'b0, got);
                chk(got, ~rows[i].data);
                repeat (14) @(posedge clock);
                chk(status.masterAckStatus, 8'h01);
                chk(status.serialIrqFlag, 8'h01);
                chk(sclOe, 8'h00);
                sw(iss_pkg::EV_IRQ_CLEAR, 8'h00);
                sw(iss_pkg::EV_BUF_READ, 8'h00);
            end
            mdl.stop();
            chk(status.addressed, 8'h00);
            chk(status.stopSeenFlag, 8'h01);
        end
        // collision: master holds data low against released high bits
        mdl.start();
        mdl.writeByte(8'ha1, ack);
        sw(iss_pkg::EV_BUF_READ, 8'h00);
        sw(iss_pkg::EV_BUF_WRITE, 8'hff);
        sw(iss_pkg::EV_CKP_SET, 8'h00);
        mdl.readByte(1'b1, 1'b0, got);
        chk(status.busCollisionFlag, 8'h01);
        chk(status.addressed, 8'h00);
        sw(iss_pkg::EV_BCL_CLEAR, 8'h00);
        sw(iss_pkg::EV_BUF_READ, 8'h00);
        mdl.stop();
        // ten-bit: high byte match, then a low byte that misses
        cfg.tenBitMode <= 1'b1;
        sw(iss_pkg::EV_ADDR_WRITE, 8'h06);
        mdl.start();
        sw(iss_pkg::EV_IRQ_CLEAR, 8'h00);
        mdl.writeByte(8'hf6, ack);
        chk(ack, 8'h01);
        repeat (14) @(posedge clock);
        chk(status.addressUpdateFlag, 8'h01);
        chk(status.serialIrqFlag, 8'h01);
        chk(sclOe, 8'h01);
        sw(iss_pkg::EV_IRQ_CLEAR, 8'h00);
        sw(iss_pkg::EV_BUF_READ, 8'h00);
        sw(iss_pkg::EV_ADDR_WRITE, 8'h3c);
        chk(sclOe, 8'h00);
        mdl.writeByte(8'h77, ack);
        chk(ack, 8'h00);
        repeat (14) @(posedge clock);
        chk(status.addressUpdateFlag, 8'h01);
        chk(status.serialIrqFlag, 8'h01);
        chk(status.bufferFullFlag, 8'h00);
        chk(status.clockReleaseBit, 8'h01);
        sw(iss_pkg::EV_ADDR_WRITE, 8'h06);
        mdl.stop();
        // ten-bit full match, then a data byte held by stretch enable
        cfg.stretchEnable <= 1'b1;
        mdl.start();
        mdl.writeByte(8'hf6, ack);
        sw(iss_pkg::EV_BUF_READ, 8'h00);
        sw(iss_pkg::EV_ADDR_WRITE, 8'h3c);
        mdl.writeByte(8'h3c, ack);
        chk(ack, 8'h01);
        sw(iss_pkg::EV_BUF_READ, 8'h00);
        chk(status.addressed, 8'h01);
        sw(iss_pkg::EV_ADDR_WRITE, 8'h06);
        mdl.writeByte(8'h55, ack);
        repeat (14) @(posedge clock);
        chk(status.clockReleaseBit, 8'h00);
        chk(sclOe, 8'h01);
        chk(status.rxTxBuffer, 8'h55);
        chk(status.dataNotAddressFlag, 8'h01);
        chk(status.ackTimeFlag, 8'h00);
        sw(iss_pkg::EV_CKP_SET, 8'h00);
        chk(sclOe, 8'h00);
        mdl.stop();
        report_and_stop();
    end
endmodule : i2c_slave_tx_and_10bit_rx_test
`default_nettype wire

// ===== testbench/iss_master_model.sv
// bus master model: start, stop and stretch-aware byte transfers
`timescale 1ns/100ps
`default_nettype none
module iss_master_model (
    input wire logic clock,
    input wire logic sclBus,
    input wire logic sdaBus,
    output var logic sclLow,
    output var logic sdaLow,
    output var logic hung
);
    localparam int HALF = 10;
    localparam int STALL_MAX = 4000;
    initial begin
        sclLow = 1'b0;
        sdaLow = 1'b0;
        hung = 1'b0;
    end
    // ==========================================================
    // bit level
    task automatic waitHalf();
        repeat (HALF) @(posedge clock);
    endtask : waitHalf
    // data moves one cycle after the fall, never with it
    task automatic pulse(input logic drive, output logic seen);
        int n;
        n = 0;
        @(posedge clock);
        sdaLow <= !drive;
        waitHalf();
        sclLow <= 1'b0;
        @(posedge clock);
        while (!sclBus && n < STALL_MAX) begin
            @(posedge clock);
            n++;
        end
        if (n == STALL_MAX) hung <= 1'b1;
        waitHalf();
        seen = sdaBus;
        sclLow <= 1'b1;
    endtask : pulse
    // ==========================================================
    // framing
    task automatic start();
        sdaLow <= 1'b0;
        waitHalf();
        sclLow <= 1'b0;
        waitHalf();
        sdaLow <= 1'b1;
        waitHalf();
        sclLow <= 1'b1;
        waitHalf();
    endtask : start
    task automatic stop();
        sdaLow <= 1'b1;
        waitHalf();
        sclLow <= 1'b0;
        waitHalf();
        sdaLow <= 1'b0;
        waitHalf();
    endtask : stop
    task automatic writeByte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) pulse(b[i], s);
        pulse(1'b1, s);
        ack = !s;
    endtask : writeByte
    // jam pulls data low against the slave; ackIt low gives no-ack
    task automatic readByte(input logic jam, input logic ackIt,
                            output logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            pulse(!jam, s);
            b[i] = s;
        end
        pulse(!ackIt, s);
    endtask : readByte
endmodule : iss_master_model
`default_nettype wire
